// *** crf_pkg.sv ***
// constants, types and helpers for the cpu register file block
package crf_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 24;
   localparam int NUM_GPR = 8;
   localparam int SP_IDX = 7;
   localparam int PADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_GPR0 = 8'h00;
   localparam logic [7:0] OFF_GPR7 = 8'h1C;
   localparam logic [7:0] OFF_PC = 8'h20;
   localparam logic [7:0] OFF_CCR = 8'h24;
   localparam logic [7:0] OFF_EA_DISP = 8'h28;
   localparam logic [7:0] OFF_EA_CMD = 8'h2C;
   localparam logic [7:0] OFF_EA_RES = 8'h30;
   localparam logic [7:0] OFF_CTRL = 8'h34;
   localparam logic [7:0] OFF_STATUS = 8'h38;
   // condition code bit positions
   localparam int CCR_I = 7;
   localparam int CCR_UI = 6;
   localparam int CCR_H = 5;
   localparam int CCR_U = 4;
   localparam int CCR_N = 3;
   localparam int CCR_Z = 2;
   localparam int CCR_V = 1;
   localparam int CCR_C = 0;
   // effective address command fields
   localparam int EAC_AM_LSB = 0;
   localparam int EAC_REG_LSB = 4;
   localparam int EAC_SIZE_LSB = 8;
   localparam int EAC_SHORT = 12;
   // control and status bits
   localparam int CTL_STEP = 0;
   localparam int CTL_SLEEP = 1;
   localparam int CTL_CALL = 2;
   localparam int CTL_RET = 3;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_SLEEP = 2;
   localparam int ST_BUSY = 3;
   // address windows per operating mode
   localparam logic [23:0] MASK_NORMAL = 24'h00FFFF;
   localparam logic [23:0] MASK_1M = 24'h0FFFFF;
   localparam logic [23:0] MASK_16M = 24'hFFFFFF;
   localparam int STEP_STATES = 2;
   localparam logic [23:0] INSN_BYTES = 24'h000002;
   localparam logic [31:0] SP_STEP = 32'h00000004;

   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_ADV_1M, MODE_ADV_16M
   } crf_mode_e;

   typedef enum logic [2:0] {
      AM_REG_DIRECT, AM_REG_IND, AM_REG_DISP, AM_POST_INC,
      AM_PRE_DEC, AM_ABS, AM_IMM, AM_PC_REL
   } crf_amode_e;

   function automatic logic [23:0] addr_mask(input crf_mode_e m);
      case (m)
         MODE_NORMAL: addr_mask = MASK_NORMAL;
         MODE_ADV_1M: addr_mask = MASK_1M;
         default: addr_mask = MASK_16M;
      endcase
   endfunction

   function automatic logic [31:0] size_bytes(input logic [1:0] s);
      case (s)
         2'h0: size_bytes = 32'h00000001;
         2'h1: size_bytes = 32'h00000002;
         default: size_bytes = 32'h00000004;
      endcase
   endfunction
endpackage

// *** crf_ea_unit.sv ***
// effective address former for the addressing modes
`timescale 1ns/1ps
module crf_ea_unit
   import crf_pkg::*;
(
   input wire logic [2:0] amode_i,
   input wire logic short_i,
   input wire logic [1:0] size_i,
   input wire logic [31:0] base_i,
   input wire logic [23:0] disp_i,
   input wire logic [23:0] pc_i,
   input wire crf_mode_e mode_i,
   output logic [23:0] ea_o,
   output logic wb_en_o,
   output logic [31:0] wb_val_o
);
   logic [23:0] disp_x;
   logic [23:0] raw;
   // d:16 sign-extends to the full 24-bit adder
   assign disp_x = short_i ? {{8{disp_i[15]}}, disp_i[15:0]} : disp_i;

   always_comb begin
      raw = base_i[23:0];
      wb_en_o = 1'b0;
      wb_val_o = base_i;
      case (crf_amode_e'(amode_i))
         AM_REG_DIRECT: raw = base_i[23:0];
         AM_REG_IND: raw = base_i[23:0];
         AM_REG_DISP: raw = base_i[23:0] + disp_x;
         AM_POST_INC: begin
            raw = base_i[23:0];
            wb_en_o = 1'b1;
            wb_val_o = base_i + size_bytes(size_i);
         end
         AM_PRE_DEC: begin
            wb_en_o = 1'b1;
            wb_val_o = base_i - size_bytes(size_i);
            raw = wb_val_o[23:0];
         end
         AM_ABS: raw = disp_x;
         AM_IMM: raw = disp_i;
         AM_PC_REL: raw = pc_i + disp_x;
         default: raw = base_i[23:0];
      endcase
   end

   // upper address bits beyond the mode's window are dropped
   assign ea_o = raw & addr_mask(mode_i);
endmodule

// *** crf_gpr_bank.sv ***
// eight general registers with byte-lane writes and a writeback port
`timescale 1ns/1ps
module crf_gpr_bank
   import crf_pkg::*;
#(
   parameter int NUM = 8
)(
   input wire logic ref_clk_i,
   input wire logic we_i,
   input wire logic [2:0] widx_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wb_en_i,
   input wire logic [2:0] wb_idx_i,
   input wire logic [31:0] wb_val_i,
   output logic [NUM-1:0][31:0] regs_o
);
   // no reset: contents are undefined until software loads them
   for (genvar r = 0; r < NUM; r++) begin : g_reg
      for (genvar b = 0; b < 4; b++) begin : g_lane
         // lanes 3..2 extended half, 1 high byte, 0 low byte
         always_ff @(posedge ref_clk_i) begin
            if (wb_en_i && wb_idx_i == 3'(r)) begin
               regs_o[r][8*b +: 8] <= wb_val_i[8*b +: 8];
            end else if (we_i && widx_i == 3'(r) && wstrb_i[b]) begin
               regs_o[r][8*b +: 8] <= wdata_i[8*b +: 8];
            end
         end
      end
   end

   logic [7:0] upper_sel;
   assign upper_sel = regs_o[widx_i][31:24];

   // a write that does not strobe lane 3 leaves the upper lane untouched
   chk_lane_write: assert property (@(posedge ref_clk_i)
      we_i && !wb_en_i && !wstrb_i[3] |=>
      regs_o[$past(widx_i)][31:24] == $past(upper_sel))
      else $error("unstrobed upper lane changed");
endmodule

// *** crf_top.sv ***
// cpu register file, operating modes and address forming behind apb
// Contract
// - normal mode limits addresses to 64 kbytes
// - advanced mode gives linear 16-Mbyte space
// - 1-Mbyte configuration drops upper four address bits
// - two configurations: 1 Mbyte and 16 Mbytes
// - this part runs advanced mode only
// - sixteen 16-bit, sixteen 8-bit or eight 32-bit
// - register = extended half, high byte, low byte
// - condition bits I UI H U N Z V C
// - eight addressing modes incl displacement, inc, dec
// - frequent instructions take two to four states; the step command here always takes two (STEP_STATES)
// - sleep command enters power-down state
// - older 16-bit code runs unchanged
// - 24-bit program counter, fetch ignores bit 0
// - register seven doubles as stack pointer
// - reset loads vector, sets I, rest untouched
`timescale 1ns/1ps
module crf_top
   import crf_pkg::*;
#(
   parameter bit NORMAL_MODE_EN = 1'b0
)(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic mcu_1mb_i,
   input wire logic normal_sel_i,
   input wire logic [23:0] reset_vector_i,
   input wire logic wake_i,
   output logic [23:0] fetch_addr_o,
   output logic [31:0] stack_pointer_o,
   output logic int_mask_o,
   output logic sleep_o,
   output logic busy_o
);
   typedef enum logic [1:0] {ST_RUN, ST_EXEC, ST_SLEEP} crf_state_e;

   crf_state_e state_q;
   crf_mode_e mode_q;
   logic [23:0] pc_q;
   logic [7:0] ccr_q;
   logic [23:0] disp_q;
   logic [23:0] ea_res_q;
   logic [23:0] fetch_q;
   logic [31:0] prdata_q;
   logic [1:0] cnt_q;
   logic [NUM_GPR-1:0][31:0] gpr;
   logic setup;
   logic acc;
   logic wr;
   logic hit;
   logic ea_go;
   logic step_go;
   logic sleep_go;
   logic call_go;
   logic ret_go;
   logic step_done;
   logic [2:0] ea_reg;
   logic [23:0] ea_val;
   logic ea_wb;
   logic [31:0] ea_wb_val;
   logic wb_en;
   logic [2:0] wb_idx;
   logic [31:0] wb_val;

   // merge a strobed write into the old value, one byte per strobe
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= OFF_STATUS);
   endfunction

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   assign setup = psel_i && !penable_i;
   assign acc = psel_i && penable_i;
   assign hit = mapped(paddr_i);
   assign wr = acc && pwrite_i && hit;
   // zero wait states: read data is fetched during the setup cycle
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !hit;
   assign prdata_o = prdata_q;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= 32'h00000000;
         if (hit && paddr_i <= OFF_GPR7) begin
            prdata_q <= gpr[paddr_i[4:2]];
         end else begin
            case (paddr_i)
               OFF_PC: prdata_q <= {8'h00, pc_q};
               OFF_CCR: prdata_q <= {24'h000000, ccr_q};
               OFF_EA_DISP: prdata_q <= {8'h00, disp_q};
               OFF_EA_RES: prdata_q <= {8'h00, ea_res_q};
               OFF_STATUS: begin
                  prdata_q[ST_MODE_LSB +: 2] <= mode_q;
                  prdata_q[crf_pkg::ST_SLEEP] <= sleep_o;
                  prdata_q[ST_BUSY] <= busy_o;
               end
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // operating mode, caught while reset is held
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         if (NORMAL_MODE_EN && normal_sel_i) begin
            mode_q <= MODE_NORMAL;
         end else if (mcu_1mb_i) begin
            mode_q <= MODE_ADV_1M;
         end else begin
            mode_q <= MODE_ADV_16M;
         end
      end
      // no other branch: the mode holds until the next reset
   end

   // ---------------------------------------------------------------
   // commands from the control register and the effective address command register
   // ---------------------------------------------------------------
   assign ea_go = wr && paddr_i == OFF_EA_CMD;
   assign step_go = wr && paddr_i == OFF_CTRL && state_q == ST_RUN &&
                    pwdata_i[CTL_STEP];
   assign sleep_go = wr && paddr_i == OFF_CTRL && state_q == ST_RUN &&
                     !pwdata_i[CTL_STEP] && pwdata_i[CTL_SLEEP];
   assign call_go = wr && paddr_i == OFF_CTRL && state_q == ST_RUN &&
                    pwdata_i[CTL_CALL] && !pwdata_i[CTL_RET];
   assign ret_go = wr && paddr_i == OFF_CTRL && state_q == ST_RUN &&
                   pwdata_i[CTL_RET] && !pwdata_i[CTL_CALL];
   assign step_done = state_q == ST_EXEC &&
                      cnt_q == 2'(STEP_STATES - 1);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (step_go) begin
                  state_q <= ST_EXEC;
               end else if (sleep_go) begin
                  state_q <= ST_SLEEP;
               end
            end
            ST_EXEC: begin
               if (step_done) begin
                  state_q <= ST_RUN;
               end
            end
            ST_SLEEP: begin
               if (wake_i) begin
                  state_q <= ST_RUN;
               end
            end
            default: state_q <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || state_q != ST_EXEC) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   assign busy_o = state_q == ST_EXEC;
   assign sleep_o = state_q == ST_SLEEP;

   // ---------------------------------------------------------------
   // program counter and condition codes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pc_q <= reset_vector_i;
      end else if (step_done) begin
         pc_q <= pc_q + INSN_BYTES;
      end else if (call_go) begin
         pc_q <= ea_res_q;
      end else if (wr && paddr_i == OFF_PC) begin
         pc_q <= 24'(merge({8'h00, pc_q}, pwdata_i, pstrb_i));
      end
   end

   // only the mask bit is defined by reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ccr_q[CCR_I] <= 1'b1;
      end else if (wr && paddr_i == OFF_CCR && pstrb_i[0]) begin
         ccr_q <= pwdata_i[7:0];
      end
   end

   assign int_mask_o = ccr_q[CCR_I];

   // fetch always from an even address inside the mode's window
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fetch_q <= 24'h000000;
      end else begin
         fetch_q <= {pc_q[23:1], 1'b0} & addr_mask(mode_q);
      end
   end

   assign fetch_addr_o = fetch_q;

   // ---------------------------------------------------------------
   // effective address forming
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         disp_q <= 24'h000000;
      end else if (wr && paddr_i == OFF_EA_DISP) begin
         disp_q <= 24'(merge({8'h00, disp_q}, pwdata_i, pstrb_i));
      end
   end

   assign ea_reg = pwdata_i[EAC_REG_LSB +: 3];

   crf_ea_unit u_ea (
      .amode_i(pwdata_i[EAC_AM_LSB +: 3]),
      .short_i(pwdata_i[EAC_SHORT]),
      .size_i(pwdata_i[EAC_SIZE_LSB +: 2]),
      .base_i(gpr[ea_reg]),
      .disp_i(disp_q),
      .pc_i(pc_q),
      .mode_i(mode_q),
      .ea_o(ea_val),
      .wb_en_o(ea_wb),
      .wb_val_o(ea_wb_val)
   );

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ea_res_q <= 24'h000000;
      end else if (ea_go) begin
         ea_res_q <= ea_val;
      end
   end

   // ---------------------------------------------------------------
   // general registers; call and return move the stack pointer
   // ---------------------------------------------------------------
   always_comb begin
      wb_en = 1'b0;
      wb_idx = ea_reg;
      wb_val = ea_wb_val;
      if (ea_go && ea_wb) begin
         wb_en = 1'b1;
      end else if (call_go) begin
         wb_en = 1'b1;
         wb_idx = 3'(SP_IDX);
         wb_val = gpr[SP_IDX] - SP_STEP;
      end else if (ret_go) begin
         wb_en = 1'b1;
         wb_idx = 3'(SP_IDX);
         wb_val = gpr[SP_IDX] + SP_STEP;
      end
   end

   crf_gpr_bank #(
      .NUM(NUM_GPR)
   ) u_bank (
      .ref_clk_i(ref_clk_i),
      .we_i(wr && paddr_i <= OFF_GPR7),
      .widx_i(paddr_i[4:2]),
      .wdata_i(pwdata_i),
      .wstrb_i(pstrb_i),
      .wb_en_i(wb_en),
      .wb_idx_i(wb_idx),
      .wb_val_i(wb_val),
      .regs_o(gpr)
   );

   assign stack_pointer_o = gpr[SP_IDX];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_normal_window: assert property (
      mode_q == MODE_NORMAL |-> fetch_addr_o[23:16] == 8'h00)
      else $error("normal mode fetch above 64 kbytes");

   chk_adv_linear: assert property (
      mode_q == MODE_ADV_16M |=>
      fetch_addr_o == {$past(pc_q[23:1]), 1'b0})
      else $error("16M mode fetch differs from pc");

   chk_trunc_1mb: assert property (
      mode_q == MODE_ADV_1M |-> fetch_addr_o[23:20] == 4'h0 &&
      ea_res_q[23:20] == 4'h0)
      else $error("1M mode address kept upper bits");

   chk_strap_config: assert property (
      $fell(rst_i) && !NORMAL_MODE_EN |->
      (mode_q == MODE_ADV_1M) == $past(mcu_1mb_i))
      else $error("configuration does not follow strap");

   chk_no_normal: assert property (
      !NORMAL_MODE_EN |-> mode_q != MODE_NORMAL)
      else $error("normal mode entered on this part");

   chk_step_states: assert property (
      step_go |=> busy_o [*2] ##1 !busy_o)
      else $error("step did not take two states");

   chk_step_pc: assert property (
      step_done |=> pc_q == $past(pc_q) + INSN_BYTES &&
      !fetch_addr_o[0])
      else $error("step did not advance pc by one word");

   chk_sleep_entry: assert property (
      sleep_go |=> sleep_o ##1 (sleep_o || $past(wake_i)))
      else $error("sleep not entered or left unwoken");

   chk_sp_call: assert property (
      call_go |=> stack_pointer_o == $past(stack_pointer_o) - SP_STEP)
      else $error("call did not decrement stack pointer");

   chk_postinc_wb: assert property (
      ea_go && pwdata_i[EAC_AM_LSB +: 3] == 3'(AM_POST_INC) |->
      wb_en && wb_val ==
      gpr[ea_reg] + size_bytes(pwdata_i[EAC_SIZE_LSB +: 2]))
      else $error("post-increment without base writeback");

   chk_reset_load: assert property (
      $fell(rst_i) |-> pc_q == $past(reset_vector_i) && int_mask_o)
      else $error("reset did not load vector or set mask");

   chk_mode_stable: assert property (
      $stable(mode_q))
      else $error("operating mode changed while running");
endmodule

// *** crf_sys_model.sv ***
// far-side system model: reset vector source and wake-up source
`timescale 1ns/1ps
module crf_sys_model #(
   parameter logic [23:0] VECTOR = 24'h000000
)(
   input wire logic ref_clk_i,
   input wire logic sleep_i,
   input wire logic [7:0] wake_dly_i,
   output logic [23:0] vector_o,
   output logic wake_o
);
   logic [7:0] cnt_q = 8'h00;
   // vector table entry, odd on purpose so fetch must drop bit 0
   assign vector_o = VECTOR;
   // saturate so a long sleep never wraps into a late wake
   always @(posedge ref_clk_i) begin
      if (sleep_i !== 1'b1)
         cnt_q <= 8'h00;
      else if (cnt_q != 8'hFF)
         cnt_q <= cnt_q + 8'h01;
   end
   assign wake_o = (sleep_i === 1'b1) && (cnt_q >= wake_dly_i);
endmodule

// *** crf_top_tb.sv ***
// self-checking bench for the cpu register file block
`timescale 1ns/1ps
module crf_top_tb;
   import crf_pkg::*;
   typedef struct {
      logic [31:0] d;
      logic [31:0] m;
      logic e;
   } crf_exp_s;
   localparam logic [23:0] VEC = 24'hF23457;
   localparam logic [2:0] AMS [5] = '{3'd1, 3'd2, 3'd2, 3'd3, 3'd4};
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] pad = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [3:0] pst = 4'h0;
   logic mcu_1mb = 1'b0;
   logic nsel = 1'b0;
   logic [7:0] wdly = 8'h01;
   logic [23:0] vec, fetch, dsp;
   logic wake, sleep, busy, imask, pready, perr, sh;
   logic [31:0] prdata, sp, rnd, v, base, d, ea, wb, sz;
   logic [3:0] s;
   crf_exp_s q[$];
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;

   always #5 ref_clk_i = ~ref_clk_i;

   crf_top u_crf_top (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd),
      .pstrb_i(pst), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .mcu_1mb_i(mcu_1mb), .normal_sel_i(nsel),
      .reset_vector_i(vec), .wake_i(wake), .fetch_addr_o(fetch),
      .stack_pointer_o(sp), .int_mask_o(imask), .sleep_o(sleep),
      .busy_o(busy));

   crf_sys_model #(.VECTOR(VEC)) u_crf_sys_model (
      .ref_clk_i(ref_clk_i), .sleep_i(sleep), .wake_dly_i(wdly),
      .vector_o(vec), .wake_o(wake));

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // each transfer starts one edge after the last, so no double drive
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] dt, input logic [3:0] st);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwr <= w;
      pad <= a;
      pwd <= dt;
      pst <= st;
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do begin
         @(posedge ref_clk_i);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                     input logic [3:0] st = 4'hF);
      apb(1'b1, a, dt, st);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, input logic er);
      q.push_back('{e, m, er});
      apb(1'b0, a, 32'h0, 4'h0);
   endtask

   task automatic do_reset(input logic m1);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      mcu_1mb <= m1;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   // read monitor: oldest note against what the access phase returns
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         conclude();
      end
      if (psel && pen)
         chk("ready", 32'h1, {31'h0, pready});
      if (psel && pen && pready === 1'b1 && !pwr && q.size() > 0) begin
         chk("read data", q[0].d, prdata & q[0].m);
         chk("read error", {31'h0, q[0].e}, {31'h0, perr});
         void'(q.pop_front());
      end
   end

   initial begin
      rnd = $urandom(30);
      do_reset(1'b0);
      chk("int mask", 32'h1, {31'h0, imask});
      chk("fetch", {8'h0, VEC & 24'hFFFFFE}, {8'h0, fetch});
      rd(OFF_STATUS, 32'h2, 32'h3, 1'b0);
      rd(OFF_CCR, 32'h80, 32'h80, 1'b0);
      rd(OFF_PC, {8'h0, VEC}, 32'hFFFFFF, 1'b0);
      for (int i = 0; i < 2; i++) begin
         v = i ? 32'h7F : 32'hA5;
         wr(OFF_CCR, v, 4'h1);
         #1;
         chk("int mask", {31'h0, ~i[0]}, {31'h0, imask});
         rd(OFF_CCR, v, 32'hFF, 1'b0);
      end
      for (int r = 0; r < 8; r++) begin
         rnd = $urandom();
         v = $urandom();
         s = 4'($urandom());
         wr(8'(r * 4), rnd);
         wr(8'(r * 4), v, s);
         for (int b = 0; b < 4; b++)
            if (s[b])
               rnd[8*b +: 8] = v[8*b +: 8];
         rd(8'(r * 4), rnd, 32'hFFFFFFFF, 1'b0);
      end
      #1;
      chk("stack pointer", rnd, sp);
      for (int k = 0; k < 5; k++) begin
         base = $urandom();
         sh = (k == 2);
         dsp = sh ? 24'h00FFF0 : 24'h000120;
         d = sh ? {{16{dsp[15]}}, dsp[15:0]} : {8'h0, dsp};
         sz = (k == 3) ? 32'h2 : 32'h4;
         ea = (k == 1 || k == 2) ? base + d : (k == 4) ? base - sz : base;
         wb = (k == 3) ? base + sz : (k == 4) ? base - sz : base;
         wr(8'h0C, base);
         wr(OFF_EA_DISP, {8'h0, dsp});
         wr(OFF_EA_CMD, {19'h0, sh, 2'b00, (k == 3) ? 2'b01 : 2'b10,
                         1'b0, 3'd3, 1'b0, AMS[k]});
         rd(OFF_EA_RES, {8'h0, ea[23:0]}, 32'hFFFFFF, 1'b0);
         rd(8'h0C, wb, 32'hFFFFFFFF, 1'b0);
      end
      wr(OFF_GPR7, 32'h00001000);
      wr(OFF_CTRL, 32'h4);
      #1;
      chk("call sp", 32'h00000FFC, sp);
      rd(OFF_PC, {8'h0, ea[23:0]}, 32'hFFFFFF, 1'b0);
      wr(OFF_CTRL, 32'h8);
      #1;
      chk("return sp", 32'h00001000, sp);
      wr(OFF_PC, 32'h00123457);
      wr(OFF_CTRL, 32'h1);
      #1;
      chk("busy", 32'h1, {31'h0, busy});
      @(posedge ref_clk_i);
      #1;
      chk("busy", 32'h1, {31'h0, busy});
      @(posedge ref_clk_i);
      #1;
      chk("busy", 32'h0, {31'h0, busy});
      @(posedge ref_clk_i);
      #1;
      chk("fetch", 32'h00123458, {8'h0, fetch});
      rd(OFF_PC, 32'h00123459, 32'hFFFFFF, 1'b0);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk_i);
         wdly <= i ? 8'd12 : 8'd1;
         wr(OFF_CTRL, 32'h2);
         #1;
         chk("sleep", 32'h1, {31'h0, sleep});
         n = 0;
         while (sleep === 1'b1 && n < 60) begin
            @(posedge ref_clk_i);
            n++;
         end
         #1;
         chk("sleep long", {31'h0, i[0]}, {31'h0, n > 8});
         chk("awake", 32'h0, {31'h0, sleep});
      end
      rd(8'h3C, 32'h0, 32'hFFFFFFFF, 1'b1);
      rd(8'h02, 32'h0, 32'hFFFFFFFF, 1'b1);
      rd(OFF_EA_CMD, 32'h0, 32'hFFFFFFFF, 1'b0);
      do_reset(1'b1);
      chk("fetch", {8'h0, VEC & 24'h0FFFFE}, {8'h0, fetch});
      rd(OFF_STATUS, 32'h1, 32'h3, 1'b0);
      @(posedge ref_clk_i);
      mcu_1mb <= 1'b0;
      nsel <= 1'b1;
      wr(OFF_GPR0, 32'hFFFFFFF8);
      wr(OFF_EA_CMD, 32'h00000001);
      rd(OFF_EA_RES, 32'h000FFFF8, 32'hFFFFFF, 1'b0);
      rd(OFF_STATUS, 32'h1, 32'h3, 1'b0);
      repeat (2) @(posedge ref_clk_i);
      conclude();
   end
endmodule
